// [rtl/write_once_option_config.sv]
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "option_config_consts.svh"

// Behaviour
// - Each option register keeps only the first write after reset.
// - Before any write, each register reads its default value.
// - Powered, reset-enabled detector resets after nine low cycles, holds until recovery.
// - Detector runs in stop mode only with power and stop-enable both set.
// - Reset-enable bit gates the detector reset output.
// - Power bit turns the low-voltage detector on or off.
// - Short-recovery bit picks 32 or 4096 crystal cycle stop exit delay.
// - Watchdog rate bit picks 8176 or 262128 crystal cycle timeout.
// - Stop enable clear makes the stop instruction an illegal opcode.
// - Watchdog disable bit set turns the watchdog off.
// - EEPROM clock select picks bus clock or crystal clock for the EEPROM.
// - Monitor protect blocks EEPROM in monitor mode until security passes.
// - Variant indicator bit is read-only; writes never change it.
module write_once_option_config #(
    parameter logic VARIANT_VALUE = 1'b1 // Arbitrary value
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic crystal_clock,
    input wire logic low_supply_n,
    input wire logic supply_recovered,
    input wire logic stop_mode,
    input wire logic stop_request,
    input wire logic monitor_mode,
    input wire logic security_passed,
    input wire logic eeprom_access_req,
    input wire logic watchdog_service,
    output logic low_voltage_reset,
    output logic detector_active,
    output logic stop_allowed,
    output logic illegal_opcode,
    output logic stop_exit,
    output logic watchdog_enable,
    output logic watchdog_reset,
    output logic eeprom_clock_select,
    output logic eeprom_access_grant
);
    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    option_config_pkg::apb_req_t req;
    option_config_pkg::top_state_t state_reg;
    option_config_pkg::top_state_t state_next;
    logic sel_sys;
    logic sel_ee;
    logic sel_stat;
    logic wr_access;
    logic [7:0] sys_value;
    logic [7:0] ee_value;
    logic sys_written;
    logic ee_written;
    logic xtal_tick;
    logic det_on;
    logic [18:0] recovery_limit;
    logic [18:0] watchdog_limit;
    logic recovery_running;
    logic wd_running;
    logic wd_done;
    logic wd_enabled;

    assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};
    assign sel_sys = (req.paddr == `ADDR_SYSTEM_OPTION);
    assign sel_ee = (req.paddr == `ADDR_EEPROM_OPTION);
    assign sel_stat = (req.paddr == `ADDR_STATUS);
    assign wr_access = req.psel && req.penable && req.pwrite;

    // ----------------------------------------------------------------
    // Option registers
    // ----------------------------------------------------------------
    write_once_reg #(
        .RESET_VALUE(`RESET_SYSTEM_OPTION),
        .WRITE_MASK(8'hFB)
    ) u_system_option_config (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .wr_stb(wr_access && sel_sys),
        .wr_data(req.pwdata[7:0]),
        .value(sys_value),
        .written(sys_written)
    );

    write_once_reg #(
        .RESET_VALUE((`RESET_EEPROM_OPTION & 8'hFE) | {7'h00, VARIANT_VALUE}),
        .WRITE_MASK(8'hC0)
    ) u_eeprom_option_config (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .wr_stb(wr_access && sel_ee),
        .wr_data(req.pwdata[7:0]),
        .value(ee_value),
        .written(ee_written)
    );

    // ----------------------------------------------------------------
    // Combined next state: synchronisers, detector filter, bus answer
    // ----------------------------------------------------------------
    // The detector is powered when asked, but in stop mode it needs its stop enable too
    assign det_on = sys_value[`BIT_DETECTOR_POWER_ENABLE]
        && (!stop_mode || sys_value[`BIT_DETECTOR_STOP_ENABLE]);
    assign xtal_tick = state_reg.xtal_sync2 && !state_reg.xtal_prev;

    always_comb begin
        state_next = state_reg;
        state_next.low_sync1 = !low_supply_n;
        state_next.low_sync2 = state_reg.low_sync1;
        state_next.high_sync1 = supply_recovered;
        state_next.high_sync2 = state_reg.high_sync1;
        state_next.xtal_sync1 = crystal_clock;
        state_next.xtal_sync2 = state_reg.xtal_sync1;
        state_next.xtal_prev = state_reg.xtal_sync2;
        case (state_reg.lv_state)
            option_config_pkg::LV_IDLE: begin
                state_next.lv_count = 4'h0;
                if (det_on && state_reg.low_sync2) begin
                    state_next.lv_state = option_config_pkg::LV_FILTER;
                    state_next.lv_count = 4'h1;
                end
            end
            option_config_pkg::LV_FILTER: begin
                if (!det_on || !state_reg.low_sync2) begin
                    state_next.lv_state = option_config_pkg::LV_IDLE;
                    state_next.lv_count = 4'h0;
                    // The first low sample counts as one, so the ninth in a row trips
                end else if (state_reg.lv_count >= 4'(`LOW_SUPPLY_FILTER_CYCLES - 1)) begin
                    state_next.lv_state = option_config_pkg::LV_RESET;
                end else begin
                    state_next.lv_count = state_reg.lv_count + 4'h1;
                end
            end
            option_config_pkg::LV_RESET: begin
                // Held until the supply passes the rising threshold or the detector turns off
                if (state_reg.high_sync2 || !det_on) begin
                    state_next.lv_state = option_config_pkg::LV_IDLE;
                    state_next.lv_count = 4'h0;
                end
            end
            default: begin
                state_next.lv_state = option_config_pkg::LV_IDLE;
                state_next.lv_count = 4'h0;
            end
        endcase
        state_next.rsp.pready = 1'b1;
        state_next.rsp.pslverr = 1'b0;
        state_next.rsp.prdata = 32'h0000_0000;
        if (req.psel && !req.penable) begin
            if (sel_sys) begin
                state_next.rsp.prdata = {24'h000000, sys_value};
            end else if (sel_ee) begin
                state_next.rsp.prdata = {24'h000000, ee_value};
            end else if (sel_stat) begin
                state_next.rsp.prdata = {27'h0000000, wd_running, recovery_running,
                    state_reg.lv_state == option_config_pkg::LV_RESET,
                    ee_written, sys_written};
            end else begin
                state_next.rsp.pslverr = 1'b1;
            end
        end else if (req.psel) begin
            state_next.rsp.prdata = state_reg.rsp.prdata;
            state_next.rsp.pslverr = state_reg.rsp.pslverr;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= '{lv_state: option_config_pkg::LV_IDLE, lv_count: 4'h0,
                low_sync1: 1'b0, low_sync2: 1'b0, high_sync1: 1'b0, high_sync2: 1'b0,
                xtal_sync1: 1'b0, xtal_sync2: 1'b0, xtal_prev: 1'b0,
                rsp: '{prdata: 32'h0000_0000, pready: 1'b1, pslverr: 1'b0}};
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Stop recovery and watchdog timing
    // ----------------------------------------------------------------
    assign recovery_limit = sys_value[`BIT_SHORT_RECOVERY_SELECT]
        ? 19'(`SHORT_RECOVERY_CYCLES) : 19'(`LONG_RECOVERY_CYCLES);
    assign watchdog_limit = sys_value[`BIT_WATCHDOG_RATE_SELECT]
        ? 19'(`WATCHDOG_SHORT_CYCLES) : 19'(`WATCHDOG_LONG_CYCLES);
    assign wd_enabled = !sys_value[`BIT_WATCHDOG_DISABLE];

    xtal_delay_counter u_recovery (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .start(stop_mode && !recovery_running && !stop_exit),
        .stop(1'b0),
        .tick(xtal_tick),
        .limit(recovery_limit),
        .done(stop_exit),
        .running(recovery_running)
    );

    // Servicing restarts the count; disabling parks it so no stale timeout fires
    xtal_delay_counter u_watchdog (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .start(wd_enabled && (watchdog_service || !wd_running)),
        .stop(!wd_enabled),
        .tick(xtal_tick),
        .limit(watchdog_limit),
        .done(wd_done),
        .running(wd_running)
    );

    // ----------------------------------------------------------------
    // Outputs driven from the stored options, the bus answer, the detector and the timers
    // ----------------------------------------------------------------
    assign prdata = state_reg.rsp.prdata;
    assign pready = state_reg.rsp.pready;
    assign pslverr = state_reg.rsp.pslverr && req.psel && req.penable;
    assign detector_active = det_on;
    assign low_voltage_reset = sys_value[`BIT_DETECTOR_RESET_ENABLE]
        && state_reg.lv_state == option_config_pkg::LV_RESET;
    assign stop_allowed = sys_value[`BIT_STOP_ENABLE];
    assign illegal_opcode = stop_request && !sys_value[`BIT_STOP_ENABLE];
    assign watchdog_enable = wd_enabled;
    assign watchdog_reset = wd_done && wd_enabled;
    assign eeprom_clock_select = ee_value[`BIT_EEPROM_CLOCK_SELECT];
    assign eeprom_access_grant = eeprom_access_req && !(monitor_mode
        && ee_value[`BIT_EEPROM_MONITOR_PROTECT] && !security_passed);
endmodule : write_once_option_config

// [rtl/option_config_consts.svh]
`ifndef OPTION_CONFIG_CONSTS_SVH
`define OPTION_CONFIG_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_SYSTEM_OPTION 12'h000
`define ADDR_EEPROM_OPTION 12'h004
`define ADDR_STATUS 12'h008

// ----------------------------------------------------------------
// System option field positions
// ----------------------------------------------------------------
`define BIT_DETECTOR_STOP_ENABLE 7
`define BIT_DETECTOR_RESET_ENABLE 6
`define BIT_DETECTOR_POWER_ENABLE 5
`define BIT_SHORT_RECOVERY_SELECT 4
`define BIT_WATCHDOG_RATE_SELECT 3
`define BIT_STOP_ENABLE 1
`define BIT_WATCHDOG_DISABLE 0

// ----------------------------------------------------------------
// EEPROM option field positions
// ----------------------------------------------------------------
`define BIT_EEPROM_CLOCK_SELECT 7
`define BIT_EEPROM_MONITOR_PROTECT 6
`define BIT_VARIANT_INDICATOR 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RESET_SYSTEM_OPTION 8'h00
`define RESET_EEPROM_OPTION 8'h00

// ----------------------------------------------------------------
// Timing counts, in crystal clock cycles and CPU cycles
// ----------------------------------------------------------------
`define SHORT_RECOVERY_CYCLES 32
`define LONG_RECOVERY_CYCLES 4096
`define WATCHDOG_SHORT_CYCLES 8176
`define WATCHDOG_LONG_CYCLES 262128
`define LOW_SUPPLY_FILTER_CYCLES 9

`endif

// [rtl/option_config_pkg.sv]
package option_config_pkg;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [7:0] value;
        logic written;
    } once_state_t;

    typedef struct packed {
        logic [18:0] count;
        logic running;
        logic done;
    } delay_state_t;

    typedef enum logic [2:0] {
        LV_IDLE = 3'b001,
        LV_FILTER = 3'b010,
        LV_RESET = 3'b100
    } lv_state_t;

    typedef struct packed {
        lv_state_t lv_state;
        logic [3:0] lv_count;
        logic low_sync1;
        logic low_sync2;
        logic high_sync1;
        logic high_sync2;
        logic xtal_sync1;
        logic xtal_sync2;
        logic xtal_prev;
        apb_rsp_t rsp;
    } top_state_t;

endpackage : option_config_pkg

// [rtl/write_once_reg.sv]
`timescale 1ns/100ps

// One configuration byte that takes only the first write after reset.
module write_once_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hFF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    output logic [7:0] value,
    output logic written
);
    option_config_pkg::once_state_t state_reg;
    option_config_pkg::once_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (wr_stb && !state_reg.written) begin
            // Bits outside the mask keep their reset value for good
            state_next.value = (wr_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
            state_next.written = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= '{value: RESET_VALUE, written: 1'b0};
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.value;
    assign written = state_reg.written;
endmodule : write_once_reg

// [rtl/xtal_delay_counter.sv]
`timescale 1ns/100ps

// Counts crystal clock ticks from a start pulse; done pulses at the limit.
module xtal_delay_counter (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic stop,
    input wire logic tick,
    input wire logic [18:0] limit,
    output logic done,
    output logic running
);
    option_config_pkg::delay_state_t state_reg;
    option_config_pkg::delay_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        if (stop) begin
            state_next.running = 1'b0;
            state_next.count = '0;
        end else if (start) begin
            state_next.running = 1'b1;
            state_next.count = '0;
        end else if (state_reg.running && tick) begin
            if (state_reg.count + 19'h00001 >= limit) begin
                state_next.done = 1'b1;
                state_next.running = 1'b0;
                state_next.count = '0;
            end else begin
                state_next.count = state_reg.count + 19'h00001;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= '{count: 19'h00000, running: 1'b0, done: 1'b0};
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign done = state_reg.done;
    assign running = state_reg.running;
endmodule : xtal_delay_counter

// [dv/write_once_option_config_props.sv]
`timescale 1ns/100ps
module option_config_props #(
    parameter logic VARIANT_VALUE = 1'h1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic low_supply_n,
    input wire logic supply_recovered,
    input wire logic stop_request,
    input wire logic eeprom_access_req,
    input wire logic low_voltage_reset,
    input wire logic stop_allowed,
    input wire logic illegal_opcode,
    input wire logic stop_exit,
    input wire logic watchdog_enable,
    input wire logic watchdog_reset,
    input wire logic eeprom_clock_select,
    input wire logic eeprom_access_grant
);
    logic wr_go;
    logic sys_done;
    logic ee_done;
    logic [3:0] low_cnt;
    assign wr_go = psel && penable && pwrite && ce;
    // ------------------------------------------------------------
    // Seen writes and length of the current low-supply run
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sys_done <= 1'h0;
            ee_done <= 1'h0;
            low_cnt <= 4'h0;
        end else begin
            sys_done <= sys_done || (wr_go && paddr == 12'h000);
            ee_done <= ee_done || (wr_go && paddr == 12'h004);
            low_cnt <= low_supply_n ? 4'h0 : (low_cnt == 4'hF ? low_cnt : low_cnt + 4'h1);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sys_once_a: assert property (
        sys_done |=> $stable(stop_allowed) && $stable(watchdog_enable)) else $error("sys moved");
    ee_once_a: assert property (
        ee_done |=> $stable(eeprom_clock_select)) else $error("eeprom option moved");
    stop_gate_a: assert property (
        illegal_opcode == (stop_request && !stop_allowed)) else $error("illegal opcode wrong");
    grant_gate_a: assert property (
        eeprom_access_grant |-> eeprom_access_req) else $error("grant without request");
    lv_filter_a: assert property (
        $rose(low_voltage_reset) |-> low_cnt >= 4'h9) else $error("detector reset too early");
    lv_hold_a: assert property (
        low_voltage_reset && !supply_recovered |=> low_voltage_reset) else $error("reset dropped");
    wd_gate_a: assert property (
        watchdog_reset |-> watchdog_enable) else $error("watchdog fired while off");
    exit_pulse_a: assert property (
        stop_exit |=> !stop_exit) else $error("stop exit not one cycle");
    variant_bit_a: assert property (
        psel && penable && !pwrite && paddr == 12'h004 |-> prdata[0] == VARIANT_VALUE)
        else $error("variant bit wrong");
    unmapped_err_a: assert property (
        psel && penable && paddr > 12'h008 |-> pslverr) else $error("no slave error");
    cover property ($rose(low_voltage_reset));
    cover property (stop_exit);
    cover property (watchdog_reset);
    cover property (wr_go && sys_done && paddr == 12'h000);
endmodule : option_config_props

bind write_once_option_config option_config_props #(.VARIANT_VALUE(VARIANT_VALUE)) props_i (
    .mclk(mclk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr), .low_supply_n(low_supply_n),
    .supply_recovered(supply_recovered), .stop_request(stop_request),
    .eeprom_access_req(eeprom_access_req), .low_voltage_reset(low_voltage_reset),
    .stop_allowed(stop_allowed), .illegal_opcode(illegal_opcode), .stop_exit(stop_exit),
    .watchdog_enable(watchdog_enable), .watchdog_reset(watchdog_reset),
    .eeprom_clock_select(eeprom_clock_select), .eeprom_access_grant(eeprom_access_grant));

// [dv/write_once_option_config_tb_top.sv]
`timescale 1ns/100ps
`define CHECK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("wrong value %s expected %0h seen %0h", what, exp, got); \
        end \
    end
`define WAIT_FOR(cond, lim) \
    n = 0; \
    while (!(cond) && n < (lim)) begin \
        @(posedge mclk); \
        n++; \
    end \
    limit(n, lim);

module write_once_option_config_tb_top;
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic err;
        logic [2:0] side;
    } row_t;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    option_config_pkg::apb_req_t req = '0;
    logic low_supply_n = 1'h1;
    logic supply_recovered = 1'h1;
    logic stop_mode = 1'h0;
    logic stop_request = 1'h0;
    logic monitor_mode = 1'h0;
    logic security_passed = 1'h0;
    logic eeprom_access_req = 1'h0;
    logic watchdog_service = 1'h0;
    logic [1:0] xdiv = 2'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [2:0] side_out;
    logic pready, pslverr, crystal_clock, err;
    logic low_voltage_reset, detector_active, stop_allowed, illegal_opcode, stop_exit;
    logic watchdog_enable, watchdog_reset, eeprom_clock_select, eeprom_access_grant;
    int xedges = 0;
    int mismatches = 0;
    int comparisons = 0;
    int n;
    int e0;
    // Side column: stop allowed, watchdog enabled, eeprom clock select
    row_t rows [13] = '{
        '{1'h0, 12'h000, 8'h00, 8'h00, 1'h0, 3'h2}, '{1'h0, 12'h004, 8'h00, 8'h01, 1'h0, 3'h2},
        '{1'h1, 12'h000, 8'hFA, 8'h00, 1'h0, 3'h6}, '{1'h0, 12'h000, 8'h00, 8'hFA, 1'h0, 3'h6},
        '{1'h1, 12'h000, 8'h01, 8'h00, 1'h0, 3'h6}, '{1'h0, 12'h000, 8'h00, 8'hFA, 1'h0, 3'h6},
        '{1'h1, 12'h004, 8'hFE, 8'h00, 1'h0, 3'h7}, '{1'h0, 12'h004, 8'h00, 8'hC1, 1'h0, 3'h7},
        '{1'h1, 12'h004, 8'h00, 8'h00, 1'h0, 3'h7}, '{1'h0, 12'h004, 8'h00, 8'hC1, 1'h0, 3'h7},
        '{1'h0, 12'h00C, 8'h00, 8'h00, 1'h1, 3'h7}, '{1'h1, 12'h008, 8'hFF, 8'h00, 1'h0, 3'h7},
        '{1'h0, 12'h000, 8'h00, 8'hFA, 1'h0, 3'h7}};

    write_once_option_config #(.VARIANT_VALUE(1'h1)) dut (
        .mclk(mclk), .rst(rst), .ce(ce), .paddr(req.paddr), .psel(req.psel),
        .penable(req.penable), .pwrite(req.pwrite), .pwdata(req.pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .crystal_clock(crystal_clock),
        .low_supply_n(low_supply_n), .supply_recovered(supply_recovered),
        .stop_mode(stop_mode), .stop_request(stop_request), .monitor_mode(monitor_mode),
        .security_passed(security_passed), .eeprom_access_req(eeprom_access_req),
        .watchdog_service(watchdog_service), .low_voltage_reset(low_voltage_reset),
        .detector_active(detector_active), .stop_allowed(stop_allowed),
        .illegal_opcode(illegal_opcode), .stop_exit(stop_exit),
        .watchdog_enable(watchdog_enable), .watchdog_reset(watchdog_reset),
        .eeprom_clock_select(eeprom_clock_select), .eeprom_access_grant(eeprom_access_grant));

    always #2.5 mclk = ~mclk;
    // Crystal runs at a quarter of mclk so the synchroniser never misses an edge
    always @(posedge mclk) begin
        xdiv <= xdiv + 2'h1;
        if (xdiv == 2'h1) begin
            xedges <= xedges + 1;
        end
    end
    assign crystal_clock = xdiv[1];
    assign side_out = {stop_allowed, watchdog_enable, eeprom_clock_select};

    // ------------------------------------------------------------
    // Bus and bookkeeping tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic limit(input int cnt, input int lim);
        if (cnt >= lim) begin
            mismatches++;
            wrap_up();
        end
    endtask : limit

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        req <= '{paddr: a, psel: 1'h1, penable: 1'h0, pwrite: wr, pwdata: {24'h000000, d}};
        @(posedge mclk);
        req.penable <= 1'h1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        limit(k, 50);
        q = prdata;
        e = pslverr;
        req.psel <= 1'h0;
        req.penable <= 1'h0;
    endtask : apb

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        for (int i = 0; i < 13; i++) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, err);
            @(posedge mclk);
            `CHECK("slave error", rows[i].err, err)
            if (!rows[i].wr) begin
                `CHECK("read data", {24'h000000, rows[i].rdata}, rd)
            end
            `CHECK("outputs", rows[i].side, side_out)
        end
        stop_request <= 1'h1;
        monitor_mode <= 1'h1;
        eeprom_access_req <= 1'h1;
        @(posedge mclk);
        `CHECK("illegal opcode", 1'h0, illegal_opcode)
        `CHECK("grant locked", 1'h0, eeprom_access_grant)
        security_passed <= 1'h1;
        stop_mode <= 1'h1;
        e0 = xedges;
        @(posedge mclk);
        `CHECK("grant open", 1'h1, eeprom_access_grant)
        `CHECK("detector in stop", 1'h1, detector_active)
        // The clock here stands for an external source, not a crystal
        `WAIT_FOR(stop_exit === 1'h1, 2000)
        `CHECK("short recovery", 1'h1, (xedges - e0) inside {[31:35]})
        stop_mode <= 1'h0;
        supply_recovered <= 1'h0;
        low_supply_n <= 1'h0;
        repeat (8) @(posedge mclk);
        low_supply_n <= 1'h1;
        repeat (20) @(posedge mclk);
        `CHECK("eight low cycles", 1'h0, low_voltage_reset)
        low_supply_n <= 1'h0;
        `WAIT_FOR(low_voltage_reset === 1'h1, 30)
        `CHECK("filter length", 1'h1, n inside {[10:14]})
        repeat (30) @(posedge mclk);
        `CHECK("reset held", 1'h1, low_voltage_reset)
        low_supply_n <= 1'h1;
        supply_recovered <= 1'h1;
        `WAIT_FOR(low_voltage_reset === 1'h0, 10)
        watchdog_service <= 1'h1;
        @(posedge mclk);
        watchdog_service <= 1'h0;
        e0 = xedges;
        `WAIT_FOR(watchdog_reset === 1'h1, 40000)
        `CHECK("watchdog short", 1'h1, (xedges - e0) inside {[8174:8180]})
        security_passed <= 1'h0;
        rst <= 1'h1;
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        `CHECK("reset outputs", 3'h2, side_out)
        `CHECK("stop refused", 1'h1, illegal_opcode)
        `CHECK("grant unprotected", 1'h1, eeprom_access_grant)
        supply_recovered <= 1'h0;
        low_supply_n <= 1'h0;
        stop_mode <= 1'h1;
        e0 = xedges;
        `WAIT_FOR(stop_exit === 1'h1, 20000)
        `CHECK("long recovery", 1'h1, (xedges - e0) inside {[4095:4099]})
        `CHECK("unpowered reset", 1'h0, low_voltage_reset)
        `CHECK("unpowered", 1'h0, detector_active)
        stop_mode <= 1'h0;
        low_supply_n <= 1'h1;
        supply_recovered <= 1'h1;
        // A write while frozen must not use up the single write
        ce <= 1'h0;
        apb(1'h1, 12'h000, 8'h08, rd, err);
        ce <= 1'h1;
        @(posedge mclk);
        apb(1'h1, 12'h000, 8'h21, rd, err);
        @(posedge mclk);
        apb(1'h0, 12'h000, 8'h00, rd, err);
        @(posedge mclk);
        `CHECK("write after reset", 32'h00000021, rd)
        `CHECK("watchdog off", 1'h0, watchdog_enable)
        `CHECK("powered", 1'h1, detector_active)
        // Detector stays on, so only the reset-enable gate keeps the reset off
        supply_recovered <= 1'h0;
        low_supply_n <= 1'h0;
        repeat (30) @(posedge mclk);
        `CHECK("reset gated", 1'h0, low_voltage_reset)
        apb(1'h0, 12'h008, 8'h00, rd, err);
        `CHECK("detector tripped", 32'h00000005, rd)
        stop_mode <= 1'h1;
        @(posedge mclk);
        `CHECK("stop without enable", 1'h0, detector_active)
        wrap_up();
    end
endmodule : write_once_option_config_tb_top
